/* File: core/trig_pkg.sv */
package trig_pkg;

   // ------------------------------------------------------------
   // register map (word aligned byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_CMD    = 4'h4;
   localparam logic [3:0] ADDR_PERIOD = 4'h8;
   localparam logic [3:0] ADDR_NCYC   = 4'hC;

   // ctrl fields
   localparam int CTRL_SRC_LSB   = 0;   // 4-bit source code
   localparam int CTRL_SLOPE_BIT = 4;
   localparam int CTRL_MODE_LSB  = 5;   // 3-bit mode code
   localparam int CTRL_GATE_BIT  = 8;   // gate/key from ext (else internal)
   // cmd strobes (write-one pulses)
   localparam int CMD_SWTRIG_BIT = 0;
   localparam int CMD_SETUP_BIT  = 1;

   // source codes: 0..7 ttltrg lines, then bus, ext, imm
   localparam logic [3:0] SRC_BUS = 4'h8;
   localparam logic [3:0] SRC_EXT = 4'h9;
   localparam logic [3:0] SRC_IMM = 4'hA;

   localparam logic [2:0] MODE_OFF   = 3'h0;
   localparam logic [2:0] MODE_BURST = 3'h1;
   localparam logic [2:0] MODE_SWEEP = 3'h2;
   localparam logic [2:0] MODE_GATED = 3'h3;
   localparam logic [2:0] MODE_FSK   = 3'h4;

   localparam logic       SLOPE_POS_RST  = 1'b0;
   localparam logic [31:0] PERIOD_RST    = 32'h0007_A120; // 100 Hz at 50 MHz
   localparam logic [15:0] NCYC_RST      = 16'h0001;

   // external pulse minimum width in ns and in clocks
   localparam int CLK_NS          = 20;
   localparam int MIN_PULSE_NS    = 2000;
   localparam int MIN_PULSE_CYC   = MIN_PULSE_NS / CLK_NS;

   typedef struct packed {
      logic [3:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } av_req_t;

   typedef struct packed {
      logic        gate_src_ext;
      logic [2:0]  mode;
      logic        slope_neg;
      logic [3:0]  source;
   } ctrl_t;

endpackage

/* File: core/edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser with rise/fall pulse outputs
module edge_sync
   import trig_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level = sync_reg;
   assign rise  = sync_reg & ~last_reg;
   assign fall  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

/* File: core/trigger_select.sv */
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// - triggers start only counted bursts and sweeps, never gated or fsk
// - slope polarity selectable for external and ttltrg sources
// - positive: rising external edge, falling ttltrg edge
// - negative: falling external edge, rising ttltrg edge
// - gating and fsk keying ignore slope setting
// - exactly one source: bus, external, immediate, or ttltrg 0..7
// - source resets to immediate
// - combined output setup command forces source to immediate
// - internal timer repeats at burst rate or sweep time
// - one burst or sweep per qualifying hardware edge; edges during a running burst are ignored
// - bus mode: one burst or sweep per software trigger or get; requests during a running burst are ignored
// - sweep mode, hardware source: one sweep per qualifying edge
// - fsk keyed: carrier when input low, hop when high
// - counted burst: exactly configured cycle count per trigger
// - gated burst: carrier while input high, output off when low
module trigger_select
   import trig_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        ext_trig_in,
   input  wire logic [7:0]  ttltrg_in,
   input  wire logic        get_msg,
   input  wire logic        cycle_done,
   output logic             burst_start,
   output logic             sweep_start,
   output logic             output_enable,
   output logic             fsk_hop,
   output logic             burst_active
);

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   logic       ext_lvl;
   logic       ext_rise;
   logic       ext_fall;
   logic [7:0] ttl_lvl;
   logic [7:0] ttl_rise;
   logic [7:0] ttl_fall;

   edge_sync u_ext_sync (
      .clock    (clock),
      .reset_n  (reset_n),
      .async_in (ext_trig_in),
      .level    (ext_lvl),
      .rise     (ext_rise),
      .fall     (ext_fall)
   );

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_ttl
         edge_sync u_ttl_sync (
            .clock    (clock),
            .reset_n  (reset_n),
            .async_in (ttltrg_in[gi]),
            .level    (ttl_lvl[gi]),
            .rise     (ttl_rise[gi]),
            .fall     (ttl_fall[gi])
         );
      end
   endgenerate

   // get is a same-clock pulse from the host interface
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   ctrl_t        ctrl_reg;
   ctrl_t        ctrl_next;
   logic [31:0]  period_reg;
   logic [31:0]  period_next;
   logic [15:0]  ncyc_reg;
   logic [15:0]  ncyc_next;
   logic [31:0]  rdata_reg;
   logic [31:0]  rdata_next;
   logic         wait_reg;
   logic         wait_next;
   logic         swtrig_reg;
   logic         swtrig_next;

   function automatic logic is_ttl(input logic [3:0] s);
      return s[3] == 1'b0;
   endfunction

   logic acc;
   logic wr_commit;
   logic [15:0] count_reg;
   logic [15:0] count_next;
   logic        active_reg;
   logic        active_next;

   // one wait cycle on every access: answer on the second edge
   assign acc = (read | write) & wait_reg;
   // writes land only on the edge that completes the transfer
   assign wr_commit = write & ~wait_reg;

   always_comb
   begin
      ctrl_next   = ctrl_reg;
      period_next = period_reg;
      ncyc_next   = ncyc_reg;
      rdata_next  = rdata_reg;
      wait_next   = 1'b1;
      swtrig_next = 1'b0;
      if (acc)
         wait_next = 1'b0;
      if (wr_commit)
      begin
         unique case (address)
            ADDR_CTRL:
            begin
               // illegal source codes keep previous source
               if (writedata[CTRL_SRC_LSB +: 4] <= SRC_IMM)
                  ctrl_next.source = writedata[CTRL_SRC_LSB +: 4];
               ctrl_next.slope_neg    = writedata[CTRL_SLOPE_BIT];
               ctrl_next.mode         = writedata[CTRL_MODE_LSB +: 3];
               ctrl_next.gate_src_ext = writedata[CTRL_GATE_BIT];
            end
            ADDR_CMD:
            begin
               swtrig_next = writedata[CMD_SWTRIG_BIT];
               if (writedata[CMD_SETUP_BIT])
               begin
                  ctrl_next.source    = SRC_IMM;
                  ctrl_next.slope_neg = SLOPE_POS_RST;
               end
            end
            ADDR_PERIOD:
               period_next = (writedata == 32'h0000_0000) ?
                             32'h0000_0001 : writedata;
            ADDR_NCYC:
               ncyc_next = (writedata[15:0] == 16'h0000) ?
                           16'h0001 : writedata[15:0];
            default:
               ;
         endcase
      end
      if (acc && read)
      begin
         unique case (address)
            ADDR_CTRL:
               rdata_next = {23'h0, ctrl_reg};
            ADDR_CMD:
               rdata_next = {31'h0, active_reg};
            ADDR_PERIOD:
               rdata_next = period_reg;
            ADDR_NCYC:
               rdata_next = {16'h0, ncyc_reg};
            default:
               rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         ctrl_reg   <= '{gate_src_ext: 1'b0, mode: MODE_OFF,
                         slope_neg: SLOPE_POS_RST, source: SRC_IMM};
         period_reg <= PERIOD_RST;
         ncyc_reg   <= NCYC_RST;
         rdata_reg  <= 32'h0000_0000;
         wait_reg   <= 1'b1;
         swtrig_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg   <= ctrl_next;
         period_reg <= period_next;
         ncyc_reg   <= ncyc_next;
         rdata_reg  <= rdata_next;
         wait_reg   <= wait_next;
         swtrig_reg <= swtrig_next;
      end
   end

   assign readdata    = rdata_reg;
   assign waitrequest = wait_reg;

   // ------------------------------------------------------------
   // trigger qualification
   // ------------------------------------------------------------
   logic        hw_edge;
   logic        sel_rise;
   logic        sel_fall;
   logic        timer_tick;
   logic        trig;
   logic [31:0] timer_reg;
   logic [31:0] timer_next;

   always_comb
   begin
      sel_rise = ext_rise;
      sel_fall = ext_fall;
      if (is_ttl(ctrl_reg.source))
      begin
         sel_rise = ttl_rise[ctrl_reg.source[2:0]];
         sel_fall = ttl_fall[ctrl_reg.source[2:0]];
      end
      // ttltrg is ground true, so its polarity is inverted
      if (is_ttl(ctrl_reg.source) ^ ctrl_reg.slope_neg)
         hw_edge = sel_fall;
      else
         hw_edge = sel_rise;
      if (!(is_ttl(ctrl_reg.source) || ctrl_reg.source == SRC_EXT))
         hw_edge = 1'b0;
   end

   // timer free-runs only with immediate source selected
   always_comb
   begin
      timer_next = 32'h0000_0000;
      timer_tick = 1'b0;
      if (ctrl_reg.source == SRC_IMM)
      begin
         if (timer_reg >= period_reg - 32'h0000_0001)
            timer_tick = 1'b1;
         else
            timer_next = timer_reg + 32'h0000_0001;
      end
   end

   // one source at a time
   assign trig = hw_edge | timer_tick |
                 ((ctrl_reg.source == SRC_BUS) & (swtrig_reg | get_msg));

   // ------------------------------------------------------------
   // burst counter and outputs
   // ------------------------------------------------------------
   logic bstart_next;
   logic sstart_next;
   logic oe_next;
   logic hop_next;
   logic bstart_reg;
   logic sstart_reg;
   logic oe_reg;
   logic hop_reg;

   always_comb
   begin
      count_next  = count_reg;
      active_next = active_reg;
      bstart_next = 1'b0;
      sstart_next = 1'b0;
      hop_next    = 1'b0;
      oe_next     = 1'b1;
      unique case (ctrl_reg.mode)
         MODE_BURST:
         begin
            // a trigger during a running burst is ignored
            if (trig && !active_reg)
            begin
               bstart_next = 1'b1;
               active_next = 1'b1;
               count_next  = ncyc_reg;
            end
            else if (active_reg && cycle_done)
            begin
               count_next = count_reg - 16'h0001;
               if (count_reg == 16'h0001)
                  active_next = 1'b0;
            end
            oe_next = active_reg;
         end
         MODE_SWEEP:
            sstart_next = trig;
         MODE_GATED:
         begin
            active_next = 1'b0;
            // level only, slope ignored
            oe_next = ctrl_reg.gate_src_ext ? ext_lvl : 1'b1;
         end
         MODE_FSK:
         begin
            active_next = 1'b0;
            hop_next = ctrl_reg.gate_src_ext & ext_lvl;
         end
         default:
            active_next = 1'b0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         timer_reg  <= 32'h0000_0000;
         count_reg  <= 16'h0000;
         active_reg <= 1'b0;
         bstart_reg <= 1'b0;
         sstart_reg <= 1'b0;
         oe_reg     <= 1'b1;
         hop_reg    <= 1'b0;
      end
      else
      begin
         timer_reg  <= timer_next;
         count_reg  <= count_next;
         active_reg <= active_next;
         bstart_reg <= bstart_next;
         sstart_reg <= sstart_next;
         oe_reg     <= oe_next;
         hop_reg    <= hop_next;
      end
   end

   assign burst_start   = bstart_reg;
   assign sweep_start   = sstart_reg;
   assign output_enable = oe_reg;
   assign fsk_hop       = hop_reg;
   assign burst_active  = active_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_reset_src;
      @(posedge clock) !reset_n |=> ctrl_reg.source == SRC_IMM;
   endproperty
   a_reset_src: assert property (p_reset_src)
      else $error("source not immediate after reset");

   property p_setup_src;
      @(posedge clock) disable iff (!reset_n)
      wr_commit && address == ADDR_CMD && writedata[CMD_SETUP_BIT]
      |=> ctrl_reg.source == SRC_IMM;
   endproperty
   a_setup_src: assert property (p_setup_src)
      else $error("setup command left source unchanged");

   property p_no_trig_gated;
      @(posedge clock) disable iff (!reset_n)
      (ctrl_reg.mode == MODE_GATED || ctrl_reg.mode == MODE_FSK)
      |=> !burst_start && !sweep_start;
   endproperty
   a_no_trig_gated: assert property (p_no_trig_gated)
      else $error("trigger started gated or fsk operation");

   property p_ext_pos;
      @(posedge clock) disable iff (!reset_n)
      ctrl_reg.source == SRC_EXT && !ctrl_reg.slope_neg && ext_rise &&
      ctrl_reg.mode == MODE_SWEEP |=> sweep_start;
   endproperty
   a_ext_pos: assert property (p_ext_pos)
      else $error("rising external edge missed");

   property p_ttl_neg;
      @(posedge clock) disable iff (!reset_n)
      is_ttl(ctrl_reg.source) && ctrl_reg.slope_neg &&
      ttl_fall[ctrl_reg.source[2:0]] && ctrl_reg.mode == MODE_SWEEP
      |=> !sweep_start;
   endproperty
   a_ttl_neg: assert property (p_ttl_neg)
      else $error("ttl falling edge fired with negative slope");

   property p_bus;
      @(posedge clock) disable iff (!reset_n)
      ctrl_reg.source != SRC_BUS && !is_ttl(ctrl_reg.source) &&
      ctrl_reg.source != SRC_IMM && !ext_rise && !ext_fall
      |=> !sweep_start;
   endproperty
   a_bus: assert property (p_bus)
      else $error("sweep started without selected source");

   property p_fsk;
      @(posedge clock) disable iff (!reset_n)
      ctrl_reg.mode == MODE_FSK && ctrl_reg.gate_src_ext
      |=> fsk_hop == $past(ext_lvl);
   endproperty
   a_fsk: assert property (p_fsk)
      else $error("fsk hop does not follow input");

   property p_gate;
      @(posedge clock) disable iff (!reset_n)
      ctrl_reg.mode == MODE_GATED && ctrl_reg.gate_src_ext
      |=> output_enable == $past(ext_lvl);
   endproperty
   a_gate: assert property (p_gate)
      else $error("gated output does not follow input");

   property p_burst_len;
      @(posedge clock) disable iff (!reset_n)
      ctrl_reg.mode == MODE_BURST && burst_active && count_reg == 16'h0001
      && cycle_done |=> !burst_active;
   endproperty
   a_burst_len: assert property (p_burst_len)
      else $error("burst did not end after last cycle");

   c_burst: cover property (@(posedge clock) burst_start);
   c_sweep: cover property (@(posedge clock) sweep_start);
   c_hop:   cover property (@(posedge clock) fsk_hop);
endmodule
`default_nettype wire

/* File: testbench/trig_sources.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: front trigger pin and backplane
// ----------------------------------------
module trig_sources
   import trig_pkg::*;
#(
   parameter int PULSE = MIN_PULSE_CYC + 10
)
(
   input  wire logic       clock,
   input  wire logic       fire,
   input  wire logic [3:0] line,
   input  wire logic       ext_level,
   output logic            ext_trig_in,
   output logic [7:0]      ttltrg_in,
   output logic            busy
);
   int         count = 0;
   logic [3:0] line_reg = 4'h0;

   // pulse held a fixed width, longer than the pin minimum
   always @(posedge clock)
   begin
      if (count == 0 && fire)
      begin
         count <= PULSE;
         line_reg <= line;
      end
      else if (count != 0)
         count <= count - 1;
   end

   assign busy = (count != 0);
   assign ext_trig_in = ext_level ^ (busy && line_reg == SRC_EXT);
   // backplane lines idle high, asserted low
   assign ttltrg_in = ~((busy && line_reg < 4'h8) ?
                        (8'h01 << line_reg[2:0]) : 8'h00);
endmodule
`default_nettype wire

/* File: testbench/burst_sweep_trigger_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module burst_sweep_trigger_select_tb
   import trig_pkg::*;
;
   localparam int PULSE = MIN_PULSE_CYC + 10;
   typedef struct {logic k; int lo; int hi;} note_t;
   logic        clock, reset_n, read, write, get_msg, cycle_done;
   logic [3:0]  address, line_sel;
   logic [31:0] writedata, readdata, rd;
   logic        waitrequest, ext_trig_in, burst_start, sweep_start;
   logic        output_enable, fsk_hop, burst_active;
   logic [7:0]  ttltrg_in;
   logic        fire, ext_level, busy, done_en, prev_act;
   int          errors, checked, cyc, ncyc, cnt, imm_per, last_t, n_imm;
   note_t       q[$];

   trigger_select trigger_select_inst (.clock(clock), .reset_n(reset_n),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .ext_trig_in(ext_trig_in),
      .ttltrg_in(ttltrg_in), .get_msg(get_msg), .cycle_done(cycle_done),
      .burst_start(burst_start), .sweep_start(sweep_start),
      .output_enable(output_enable), .fsk_hop(fsk_hop),
      .burst_active(burst_active));
   trig_sources trig_sources_inst (.clock(clock), .fire(fire),
      .line(line_sel), .ext_level(ext_level), .ext_trig_in(ext_trig_in),
      .ttltrg_in(ttltrg_in), .busy(busy));

   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ----------------------------------------
   // checking and reporting
   // ----------------------------------------
   task automatic results();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic fail(string n);
      errors++;
      $display("MISMATCH %s exp done got timeout", n);
      results();
   endtask

   task automatic cmp_word(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask

   task automatic cmp_start(note_t n, logic k);
      checked++;
      if (n.k !== k || cyc < n.lo || cyc > n.hi)
      begin
         errors++;
         $display("MISMATCH start exp %0d@%0d got %0d@%0d",
                  n.k, n.lo, k, cyc);
      end
   endtask

   function automatic logic [31:0] cw(logic [3:0] s, logic n,
                                      logic [2:0] m, logic g);
      cw = {23'h0, g, m, n, s};
   endfunction

   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      int i;
      @(posedge clock);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clock);
         if (waitrequest === 1'b0)
            break;
      end
      if (i == 20)
         fail("waitrequest");
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic expect_start(logic k, int base);
      q.push_back('{k, base + 1, base + 8});
   endtask

   task automatic drain();
      int i;
      for (i = 0; i < 500 && (q.size() > 0 || burst_active !== 1'b0); i++)
         @(posedge clock);
      if (i == 500)
         fail("drain");
   endtask

   // active edge is the pulse start for pos slope, its end for neg
   task automatic pulse(logic [3:0] l, logic neg, logic e, logic k);
      int i;
      @(posedge clock);
      fire <= 1'b1;
      line_sel <= l;
      @(posedge clock);
      fire <= 1'b0;
      if (e)
         expect_start(k, cyc + (neg ? PULSE : 0));
      @(posedge clock);
      for (i = 0; i < 300 && (busy || q.size() > 0); i++)
         @(posedge clock);
      if (i == 300)
         fail("pulse");
      repeat (8) @(posedge clock);
   endtask

   task automatic lvl(bit h, logic e);
      int i;
      for (i = 0; i < 10 && (h ? fsk_hop : output_enable) !== e; i++)
         @(posedge clock);
      cmp_word(h ? "fsk_hop" : "output_enable", {31'h0, e},
               {31'h0, h ? fsk_hop : output_enable});
   endtask

   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (5) @(posedge clock);
      reset_n <= 1'b1;
   endtask

   // ----------------------------------------
   // monitor
   // ----------------------------------------
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      cycle_done <= done_en && ($urandom % 8 == 0);
      prev_act <= burst_active;
      if (burst_active === 1'b1)
         cnt <= cnt + int'(cycle_done);
      if (prev_act === 1'b1 && burst_active === 1'b0)
      begin
         cmp_word("cycles", ncyc, cnt);
         cnt <= 0;
      end
      if (burst_start === 1'b1 || sweep_start === 1'b1)
      begin
         if (imm_per != 0)
         begin
            if (last_t != 0)
               cmp_word("period", imm_per, cyc - last_t);
            last_t <= cyc;
            n_imm <= n_imm + 1;
         end
         else if (q.size() == 0)
            fail("no start");
         else
            cmp_start(q.pop_front(), sweep_start);
      end
   end

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      void'($urandom(84));
      reset_n = 1'b0;
      {read, write, get_msg, cycle_done, fire, ext_level} = 6'h00;
      {address, line_sel, writedata} = 40'h0;
      {done_en, prev_act, cyc, imm_per, last_t, n_imm} = 0;
      done_en = 1'b1;
      do_reset();
      bus(0, ADDR_CTRL, 0);
      cmp_word("ctrl", cw(SRC_IMM, 0, MODE_OFF, 0), rd);
      bus(0, ADDR_PERIOD, 0);
      cmp_word("period", PERIOD_RST, rd);
      bus(0, ADDR_NCYC, 0);
      cmp_word("ncyc", {16'h0, NCYC_RST}, rd);
      bus(0, 4'h2, 0);
      cmp_word("unmapped", 32'h0, rd);
      bus(1, ADDR_PERIOD, 32'h0000_000A);
      imm_per <= 10;
      bus(1, ADDR_CTRL, cw(SRC_IMM, 0, MODE_SWEEP, 0));
      repeat (60) @(posedge clock);
      bus(1, ADDR_CTRL, cw(SRC_IMM, 0, MODE_OFF, 0));
      repeat (12) @(posedge clock);
      imm_per <= 0;
      cmp_word("timer", 32'h1, {31'h0, n_imm >= 5});
      for (int s = 0; s < 10; s++)
         for (int n = 0; n < 2; n++)
         begin
            if (s == 8)
               continue;
            bus(1, ADDR_CTRL, cw(4'(s), 1'(n), MODE_SWEEP, 0));
            pulse(s == 9 ? 4'h0 : 4'((s + 1) % 8), 1'(n), 0, 1);
            pulse(4'(s), 1'(n), 1, 1);
         end
      ncyc = 3 + $urandom % 4;
      bus(1, ADDR_NCYC, 32'(ncyc));
      bus(1, ADDR_CTRL, cw(SRC_BUS, 0, MODE_BURST, 0));
      done_en <= 1'b0;
      bus(1, ADDR_CMD, 32'h0000_0001);
      expect_start(0, cyc - 1);
      // second request while counting must be dropped
      bus(1, ADDR_CMD, 32'h0000_0001);
      bus(0, ADDR_CMD, 0);
      cmp_word("active", 32'h1, rd);
      done_en <= 1'b1;
      drain();
      for (int m = 1; m < 3; m++)
      begin
         bus(1, ADDR_CTRL, cw(SRC_BUS, 0, 3'(m), 0));
         @(posedge clock);
         get_msg <= 1'b1;
         expect_start(m == 2, cyc);
         @(posedge clock);
         get_msg <= 1'b0;
         drain();
      end
      bus(1, ADDR_CTRL, cw(SRC_EXT, 0, MODE_BURST, 0));
      pulse(SRC_EXT, 0, 1, 0);
      drain();
      for (int m = 0; m < 4; m++)
      begin
         bus(1, ADDR_CTRL, cw(SRC_EXT, 1'(m), m < 2 ? MODE_GATED : MODE_FSK, 1));
         ext_level <= 1'b1;
         lvl(m > 1, 1);
         ext_level <= 1'b0;
         lvl(m > 1, 0);
         pulse(SRC_EXT, 1'(m), 0, 0);
      end
      bus(1, ADDR_CTRL, cw(SRC_EXT, 1, MODE_OFF, 0));
      bus(1, ADDR_CTRL, cw(4'hB, 1, MODE_OFF, 0));
      bus(0, ADDR_CTRL, 0);
      cmp_word("ctrl", cw(SRC_EXT, 1, MODE_OFF, 0), rd);
      bus(1, ADDR_CMD, 32'h0000_0002);
      bus(0, ADDR_CTRL, 0);
      cmp_word("ctrl", cw(SRC_IMM, 0, MODE_OFF, 0), rd);
      bus(1, ADDR_CTRL, cw(SRC_BUS, 1, MODE_OFF, 0));
      @(posedge clock);
      do_reset();
      bus(0, ADDR_CTRL, 0);
      cmp_word("ctrl", cw(SRC_IMM, 0, MODE_OFF, 0), rd);
      results();
   end
endmodule
`default_nettype wire
